// File: include/irq_unit_regs.svh
// Register map, field positions, reset values and vectors of the interrupt unit.
`ifndef IRQ_UNIT_REGS_SVH
`define IRQ_UNIT_REGS_SVH

`define OFS_EN_MAIN 8'ha8
`define OFS_LV_MAIN 8'hb8
`define OFS_LV_TMR2 8'hf8
`define OFS_EN_TMR2 8'he8
`define OFS_STATUS 8'hf9

`define RST_REG 8'h00
`define LV_MAIN_MASK 8'h7f

// Bit positions; enable and level registers share the same layout.
`define POS_GLOBAL 7
`define POS_ADC 6
`define POS_TWOWIRE 5
`define POS_UART 4
`define POS_TMR1 3
`define POS_PIN1 2
`define POS_TMR0 1
`define POS_PIN0 0
`define POS_TMR2 7
`define POS_CMP2 6
`define POS_CMP1 5
`define POS_CMP0 4
`define POS_CAP3 3
`define POS_CAP2 2
`define POS_CAP1 1
`define POS_CAP0 0

// Hold-off count loaded after a return, a control register access or a call.
`define HOLD_LOAD 2'd2

`define VEC_PIN0 16'h0003
`define VEC_TMR0 16'h000b
`define VEC_PIN1 16'h0013
`define VEC_TMR1 16'h001b
`define VEC_UART 16'h0023
`define VEC_TWOWIRE 16'h002b
`define VEC_CAP0 16'h0033
`define VEC_CAP1 16'h003b
`define VEC_CAP2 16'h0043
`define VEC_CAP3 16'h004b
`define VEC_ADC 16'h0053
`define VEC_CMP0 16'h005b
`define VEC_CMP1 16'h0063
`define VEC_CMP2 16'h006b
`define VEC_TMR2 16'h0073

`endif

// File: include/irq_pkg.sv
// Types shared by the interrupt unit: source codes in polling order.
`default_nettype none
package irq_pkg;

   // Source codes; the code is the polling rank, 0 is polled first.
   typedef enum logic [3:0] {
      SRC_PIN0, SRC_TWOWIRE, SRC_ADC, SRC_TMR0, SRC_CAP0,
      SRC_CMP0, SRC_PIN1, SRC_CAP1, SRC_CMP1, SRC_TMR1,
      SRC_CAP2, SRC_CMP2, SRC_UART, SRC_CAP3, SRC_TMR2
   } src_t;

   // One bit per source, indexed by src_t.
   typedef logic [14:0] src_vec_t;

endpackage : irq_pkg
`default_nettype wire

// File: rtl/rst_sync.sv
// Reset synchroniser: asynchronous assertion, release after two clock edges.
`timescale 1ns/1ps
`default_nettype none
module rst_sync (
   input wire logic clk, // Clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   output logic rst_n // Synchronised reset, active low.
);
   logic [1:0] sync_r;
   logic [1:0] sync_nxt;

   // A one shifts in after release; the first stage feeds only the second.
   always_comb begin
      sync_nxt = {sync_r[0], 1'b1};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_r <= 2'b00;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign rst_n = sync_r[1];
endmodule : rst_sync
`default_nettype wire

// File: rtl/irq_pick.sv
// Polling-order selector: first pending source of each priority level.
`timescale 1ns/1ps
`default_nettype none
module irq_pick (
   input wire irq_pkg::src_vec_t req, // Enabled sampled requests.
   input wire irq_pkg::src_vec_t high, // Level bit per source, 1 is high.
   output logic hi_hit, // Some high-level request pending.
   output irq_pkg::src_t hi_src, // First high-level request.
   output logic lo_hit, // Some low-level request pending.
   output irq_pkg::src_t lo_src // First low-level request.
);
   logic [4:0] hi_w;
   logic [4:0] lo_w;

   // Scans downward so the lowest code, the first polled, wins.
   function automatic logic [4:0] first_set(input irq_pkg::src_vec_t v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 14; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : first_set

   // Each level has its own polling chain.
   always_comb begin
      hi_w = first_set(req & high);
      lo_w = first_set(req & ~high);
      hi_hit = hi_w[4];
      hi_src = irq_pkg::src_t'(hi_w[3:0]);
      lo_hit = lo_w[4];
      lo_src = irq_pkg::src_t'(lo_w[3:0]);
   end
endmodule : irq_pick
`default_nettype wire

// File: rtl/irq_unit.sv
// Two-level vectored interrupt controller with its register port.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_regs.svh"
module irq_unit (
   input wire logic CLK, // Clock, four per machine cycle, 50 MHz.
   input wire logic RST_B, // Asynchronous reset, active low.
   input wire logic [7:0] ADDR, // Register address.
   input wire logic [7:0] WDATA, // Register write data.
   input wire logic WR, // Write strobe.
   input wire logic RD, // Read strobe.
   output logic [7:0] RDATA, // Read data, cycle after RD.
   input wire logic SAMPLE, // Sample-phase pulse, once per machine cycle.
   input wire logic INSTR_LAST, // Current cycle is an instruction's last.
   input wire logic RET_EXEC, // Return-from-interrupt executes, pulse.
   input wire irq_pkg::src_vec_t REQ, // Request flags, polling order.
   input wire logic PIN0_EDGE, // Pin 0 flag is edge triggered.
   input wire logic PIN1_EDGE, // Pin 1 flag is edge triggered.
   output logic CALL_REQ, // Forced long call, one-cycle pulse.
   output logic [15:0] VECTOR, // Call target, held until next call.
   output logic [3:0] CALL_SRC, // Source of the last call.
   output logic [1:0] LEVEL_ACT, // Level-active flops, bit 1 high.
   output logic CLR_TMR0, // Clear timer 0 overflow flag.
   output logic CLR_TMR1, // Clear timer 1 overflow flag.
   output logic CLR_PIN0, // Clear pin 0 request flag.
   output logic CLR_PIN1 // Clear pin 1 request flag.
);
   logic rst_n;
   logic [7:0] en0_r, en0_nxt, en1_r, en1_nxt;
   logic [7:0] lv0_r, lv0_nxt, lv1_r, lv1_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic acc_now;
   irq_pkg::src_vec_t snap_r, snap_nxt, en_vec, lv_vec;
   logic [1:0] hold_r, hold_nxt, act_r, act_nxt;
   logic call_r, call_nxt, call_hi_r, call_hi_nxt;
   logic [15:0] vec_r, vec_nxt;
   irq_pkg::src_t src_r, src_nxt, hi_src, lo_src, pick;
   logic hi_hit, lo_hit, take_hi, take_lo, go, blocked;
   logic [3:0] clr_r, clr_nxt;

   rst_sync u_rst (
      .clk(CLK),
      .arst_n(RST_B),
      .rst_n(rst_n)
   );

   // Gathers a per-source bit vector in polling order from the two layouts.
   function automatic irq_pkg::src_vec_t to_src(input logic [7:0] m,
                                                input logic [7:0] t);
      irq_pkg::src_vec_t v;
      v = '0;
      v[irq_pkg::SRC_PIN0] = m[`POS_PIN0];
      v[irq_pkg::SRC_TWOWIRE] = m[`POS_TWOWIRE];
      v[irq_pkg::SRC_ADC] = m[`POS_ADC];
      v[irq_pkg::SRC_TMR0] = m[`POS_TMR0];
      v[irq_pkg::SRC_CAP0] = t[`POS_CAP0];
      v[irq_pkg::SRC_CMP0] = t[`POS_CMP0];
      v[irq_pkg::SRC_PIN1] = m[`POS_PIN1];
      v[irq_pkg::SRC_CAP1] = t[`POS_CAP1];
      v[irq_pkg::SRC_CMP1] = t[`POS_CMP1];
      v[irq_pkg::SRC_TMR1] = m[`POS_TMR1];
      v[irq_pkg::SRC_CAP2] = t[`POS_CAP2];
      v[irq_pkg::SRC_CMP2] = t[`POS_CMP2];
      v[irq_pkg::SRC_UART] = m[`POS_UART];
      v[irq_pkg::SRC_CAP3] = t[`POS_CAP3];
      v[irq_pkg::SRC_TMR2] = t[`POS_TMR2];
      return v;
   endfunction : to_src

   // Vector address of each source.
   function automatic logic [15:0] vec_of(input irq_pkg::src_t s);
      logic [15:0] a;
      a = `VEC_PIN0;
      unique case (s)
         irq_pkg::SRC_PIN0: a = `VEC_PIN0;
         irq_pkg::SRC_TWOWIRE: a = `VEC_TWOWIRE;
         irq_pkg::SRC_ADC: a = `VEC_ADC;
         irq_pkg::SRC_TMR0: a = `VEC_TMR0;
         irq_pkg::SRC_CAP0: a = `VEC_CAP0;
         irq_pkg::SRC_CMP0: a = `VEC_CMP0;
         irq_pkg::SRC_PIN1: a = `VEC_PIN1;
         irq_pkg::SRC_CAP1: a = `VEC_CAP1;
         irq_pkg::SRC_CMP1: a = `VEC_CMP1;
         irq_pkg::SRC_TMR1: a = `VEC_TMR1;
         irq_pkg::SRC_CAP2: a = `VEC_CAP2;
         irq_pkg::SRC_CMP2: a = `VEC_CMP2;
         irq_pkg::SRC_UART: a = `VEC_UART;
         irq_pkg::SRC_CAP3: a = `VEC_CAP3;
         irq_pkg::SRC_TMR2: a = `VEC_TMR2;
         default: a = `VEC_PIN0;
      endcase
      return a;
   endfunction : vec_of

   // Any read or write of the four control registers opens a hold-off.
   assign acc_now = (WR || RD) && ((ADDR == `OFS_EN_MAIN) || (ADDR == `OFS_EN_TMR2)
                    || (ADDR == `OFS_LV_MAIN) || (ADDR == `OFS_LV_TMR2));

   // Register port; reads are registered so data stands one cycle after RD.
   always_comb begin
      en0_nxt = en0_r;
      en1_nxt = en1_r;
      lv0_nxt = lv0_r;
      lv1_nxt = lv1_r;
      rdata_nxt = 8'h00;
      if (WR) begin
         case (ADDR)
            `OFS_EN_MAIN: en0_nxt = WDATA;
            `OFS_EN_TMR2: en1_nxt = WDATA;
            `OFS_LV_MAIN: lv0_nxt = WDATA & `LV_MAIN_MASK;
            `OFS_LV_TMR2: lv1_nxt = WDATA;
            default: ;
         endcase
      end
      if (RD) begin
         case (ADDR)
            `OFS_EN_MAIN: rdata_nxt = en0_r;
            `OFS_EN_TMR2: rdata_nxt = en1_r;
            `OFS_LV_MAIN: rdata_nxt = lv0_r;
            `OFS_LV_TMR2: rdata_nxt = lv1_r;
            `OFS_STATUS: rdata_nxt = {act_r, 2'b00, src_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // Everything resets to zero, so no source can be accepted after reset.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         en0_r <= `RST_REG;
         en1_r <= `RST_REG;
         lv0_r <= `RST_REG;
         lv1_r <= `RST_REG;
         rdata_r <= 8'h00;
      end else begin
         en0_r <= en0_nxt;
         en1_r <= en1_nxt;
         lv0_r <= lv0_nxt;
         lv1_r <= lv1_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign en_vec = to_src(en0_r, en1_r);
   assign lv_vec = to_src(lv0_r, lv1_r);

   irq_pick u_pick (
      .req(snap_r),
      .high(lv_vec),
      .hi_hit(hi_hit),
      .hi_src(hi_src),
      .lo_hit(lo_hit),
      .lo_src(lo_src)
   );

   // Polling: a high request may preempt low service only; high service is
   // never preempted. A low request loses to any high one in the same poll.
   assign take_hi = hi_hit && !act_r[1];
   assign take_lo = !hi_hit && lo_hit && (act_r == 2'b00);
   assign blocked = (hold_r == `HOLD_LOAD) || acc_now || RET_EXEC;
   assign go = SAMPLE && INSTR_LAST && en0_r[`POS_GLOBAL] && !blocked
               && (take_hi || take_lo);
   assign pick = take_hi ? hi_src : lo_src;

   // Sampling, hold-off, level tracking and the forced call.
   always_comb begin
      snap_nxt = snap_r;
      hold_nxt = hold_r;
      act_nxt = act_r;
      call_nxt = 1'b0;
      call_hi_nxt = call_hi_r;
      vec_nxt = vec_r;
      src_nxt = src_r;
      clr_nxt = 4'h0;
      // The snapshot is overwritten every sample, so a request that dropped
      // while blocked leaves no trace; only this snapshot is ever polled.
      if (SAMPLE) begin
         snap_nxt = REQ & en_vec;
      end
      // Counts instruction ends: the accessing one, then one more must run.
      if (acc_now || RET_EXEC || go) begin
         hold_nxt = `HOLD_LOAD;
      end else if (SAMPLE && INSTR_LAST && (hold_r != 2'd0)) begin
         hold_nxt = hold_r - 2'd1;
      end
      // Return clears the highest active level; the core pops the PC itself.
      if (RET_EXEC) begin
         if (act_r[1]) begin
            act_nxt[1] = 1'b0;
         end else begin
            act_nxt[0] = 1'b0;
         end
      end
      // The call pushes only the PC; no status word is saved by the core.
      if (go) begin
         call_nxt = 1'b1;
         call_hi_nxt = take_hi;
         act_nxt[take_hi] = 1'b1;
         vec_nxt = vec_of(pick);
         src_nxt = pick;
         // Only these four flags are cleared here; software owns the rest.
         clr_nxt[0] = (pick == irq_pkg::SRC_TMR0);
         clr_nxt[1] = (pick == irq_pkg::SRC_TMR1);
         clr_nxt[2] = (pick == irq_pkg::SRC_PIN0) && PIN0_EDGE;
         clr_nxt[3] = (pick == irq_pkg::SRC_PIN1) && PIN1_EDGE;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         snap_r <= '0;
         hold_r <= 2'd0;
         act_r <= 2'b00;
         call_r <= 1'b0;
         call_hi_r <= 1'b0;
         vec_r <= 16'h0000;
         src_r <= irq_pkg::SRC_PIN0;
         clr_r <= 4'h0;
      end else begin
         snap_r <= snap_nxt;
         hold_r <= hold_nxt;
         act_r <= act_nxt;
         call_r <= call_nxt;
         call_hi_r <= call_hi_nxt;
         vec_r <= vec_nxt;
         src_r <= src_nxt;
         clr_r <= clr_nxt;
      end
   end

   // All outputs come straight from flops.
   assign RDATA = rdata_r;
   assign CALL_REQ = call_r;
   assign VECTOR = vec_r;
   assign CALL_SRC = src_r;
   assign LEVEL_ACT = act_r;
   assign CLR_TMR0 = clr_r[0];
   assign CLR_TMR1 = clr_r[1];
   assign CLR_PIN0 = clr_r[2];
   assign CLR_PIN1 = clr_r[3];

   // Checks on the call path and the level flops.
   AST_POLL_SNAPSHOT: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CALL_REQ |-> $past(snap_r != '0))
      else $error("Call issued with an empty sampled snapshot.");

   AST_GLOBAL_OFF: assert property (
      @(posedge CLK) disable iff (!rst_n)
      !en0_r[`POS_GLOBAL] && !WR |=> !CALL_REQ)
      else $error("Call issued while global enable was off.");

   AST_INSTR_END: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CALL_REQ |-> $past(SAMPLE) && $past(INSTR_LAST))
      else $error("Call issued outside an instruction end.");

   AST_ACCESS_HOLD: assert property (
      @(posedge CLK) disable iff (!rst_n)
      acc_now |=> !CALL_REQ)
      else $error("Call issued right after a control register access.");

   AST_HIGH_KEPT: assert property (
      @(posedge CLK) disable iff (!rst_n)
      act_r[1] && !RET_EXEC |=> !CALL_REQ && act_r[1])
      else $error("High-level service was preempted.");

   AST_LEVEL_SET: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CALL_REQ |-> (call_hi_r ? act_r[1] : act_r == 2'b01))
      else $error("Level-active flop not set for the taken call.");

   AST_RET_CLEAR: assert property (
      @(posedge CLK) disable iff (!rst_n)
      RET_EXEC && act_r == 2'b11 |=> act_r == 2'b01)
      else $error("Return did not clear the high level first.");

   AST_TMR_CLEAR: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CALL_REQ && src_r == irq_pkg::SRC_TMR1 |-> CLR_TMR1 && !CLR_TMR0)
      else $error("Timer 1 flag not cleared on its call.");

   AST_PIN_LEVEL: assert property (
      @(posedge CLK) disable iff (!rst_n)
      go && pick == irq_pkg::SRC_PIN0 && !PIN0_EDGE |=> !CLR_PIN0)
      else $error("Level-triggered pin flag was cleared.");

   AST_VECTOR_STEP: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CALL_REQ |-> VECTOR[2:0] == 3'h3 && VECTOR <= `VEC_TMR2)
      else $error("Vector outside the 8-byte table.");

   // With only the low level active, a return must leave no level active.
   AST_RET_LOW: assert property (
      @(posedge CLK) disable iff (!rst_n)
      RET_EXEC && act_r == 2'b01 |=> act_r == 2'b00)
      else $error("Return did not clear the low level.");

   // The instruction that returns must end without a call.
   AST_RET_HOLD: assert property (
      @(posedge CLK) disable iff (!rst_n)
      RET_EXEC |=> !CALL_REQ)
      else $error("Call issued right after a return.");

   // A timer 0 clear pulse may only ride on a timer 0 call.
   AST_CLR_OWN: assert property (
      @(posedge CLK) disable iff (!rst_n)
      CLR_TMR0 |-> CALL_REQ && src_r == irq_pkg::SRC_TMR0)
      else $error("Timer 0 flag cleared without its call.");

endmodule : irq_unit
`default_nettype wire

// File: tb/irq_core_model.sv
// Model of the core and of the peripherals that raise the request flags.
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
   input wire logic clk, // Clock.
   input wire logic slow, // One: only every other machine cycle ends an instruction.
   input wire irq_pkg::src_vec_t set_req, // Flag set pulses.
   input wire irq_pkg::src_vec_t clr_req, // Flag clears by software.
   input wire logic clr_tmr0, // Unit clears timer 0 flag.
   input wire logic clr_tmr1, // Unit clears timer 1 flag.
   input wire logic clr_pin0, // Unit clears pin 0 flag.
   input wire logic clr_pin1, // Unit clears pin 1 flag.
   output logic sample, // Sample-phase pulse.
   output logic instr_last, // Last machine cycle of an instruction.
   output irq_pkg::src_vec_t req // Request flags.
);
   logic [1:0] phase_r = 2'h0;
   logic odd_r = 1'b0;
   irq_pkg::src_vec_t hw_clr;

   // Flags the unit clears at the call; a level pin never sees a clear pulse.
   assign hw_clr = {5'h00, clr_tmr1, 2'h0, clr_pin1, 2'h0, clr_tmr0, 2'h0, clr_pin0};
   // In slow mode instructions span two machine cycles, so calls come late.
   assign instr_last = ~slow | odd_r;

   initial begin
      req = '0;
      sample = 1'b0;
   end

   // Four clocks make a machine cycle; software and hardware act alike on flags.
   always @(posedge clk) begin
      phase_r <= phase_r + 2'h1;
      sample <= (phase_r == 2'h2);
      if (phase_r == 2'h3) begin
         odd_r <= ~odd_r;
      end
      req <= (req | set_req) & ~clr_req & ~hw_clr;
   end
endmodule : irq_core_model
`default_nettype wire

// File: tb/irq_unit_tb_top.sv
// Self-checking testbench of the interrupt unit and its core model.
`timescale 1ns/1ps
`default_nettype none
module irq_unit_tb_top;
   logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ret = 1'b0, slow = 1'b0;
   logic pin0_edge = 1'b1, pin1_edge = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic call_req, clr_t0, clr_t1, clr_p0, clr_p1, sample, instr_last;
   logic [15:0] vector;
   logic [3:0] call_src;
   logic [1:0] level_act;
   irq_pkg::src_vec_t req, set_req = '0, clr_req = '0;
   int n_fail = 0, cmp_count = 0, n_calls = 0, cyc = 0;
   // Vector slot and register bit of each source, indexed by polling rank.
   int vidx[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
   int ebit[15] = '{0, 5, 6, 1, 8, 12, 2, 9, 13, 3, 10, 14, 4, 11, 15};

   always #10 clk = ~clk;

   irq_unit irq_unit_inst (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .SAMPLE(sample), .INSTR_LAST(instr_last), .RET_EXEC(ret),
      .REQ(req), .PIN0_EDGE(pin0_edge), .PIN1_EDGE(pin1_edge), .CALL_REQ(call_req),
      .VECTOR(vector), .CALL_SRC(call_src), .LEVEL_ACT(level_act), .CLR_TMR0(clr_t0),
      .CLR_TMR1(clr_t1), .CLR_PIN0(clr_p0), .CLR_PIN1(clr_p1));
   irq_core_model irq_core_model_inst (.clk(clk), .slow(slow), .set_req(set_req),
      .clr_req(clr_req), .clr_tmr0(clr_t0), .clr_tmr1(clr_t1), .clr_pin0(clr_p0),
      .clr_pin1(clr_p1), .sample(sample), .instr_last(instr_last), .req(req));

   // Counts calls and cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (call_req === 1'b1) begin
         n_calls++;
      end
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp});
   endtask : rd_reg

   // One-cycle pulses of flag sets, software clears and the return.
   task automatic pulse(input irq_pkg::src_vec_t s, input irq_pkg::src_vec_t c, input logic r);
      @(posedge clk);
      set_req <= s;
      clr_req <= c;
      ret <= r;
      @(posedge clk);
      set_req <= '0;
      clr_req <= '0;
      ret <= 1'b0;
      #1;
   endtask : pulse

   task automatic cfg(input logic g, input irq_pkg::src_vec_t en, input irq_pkg::src_vec_t hi);
      logic [15:0] e = '0;
      logic [15:0] l = '0;
      for (int i = 0; i < 15; i++) begin
         e[ebit[i]] = en[i];
         l[ebit[i]] = hi[i];
      end
      wr_reg(8'ha8, {g, e[6:0]});
      wr_reg(8'he8, e[15:8]);
      wr_reg(8'hb8, l[7:0]);
      wr_reg(8'hf8, l[15:8]);
   endtask : cfg

   // Waits for a call and judges vector, source, levels and flag clears.
   task automatic wait_call(input int s, input logic [1:0] lv);
      int k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (call_req !== 1'b1 && k < 200);
      chk({15'h0, call_req}, 16'h0001);
      chk(vector, 16'h0003 + 16'(8 * vidx[s]));
      chk({12'h000, call_src}, 16'(s));
      chk({14'h0, level_act}, {14'h0, lv});
      chk({12'h0, clr_p1, clr_p0, clr_t1, clr_t0},
          {12'h0, s == 6 && pin1_edge, s == 0 && pin0_edge, s == 9, s == 3});
   endtask : wait_call

   task automatic no_call(input int n);
      int c = n_calls;
      repeat (n) @(posedge clk);
      #1;
      chk(16'(n_calls), 16'(c));
   endtask : no_call

   task automatic t_regs;
      rd_reg(8'ha8, 8'h00);
      rd_reg(8'he8, 8'h00);
      rd_reg(8'hb8, 8'h00);
      rd_reg(8'hf8, 8'h00);
      wr_reg(8'hb8, 8'hff);
      rd_reg(8'hb8, 8'h7f);
      wr_reg(8'hf8, 8'h5a);
      rd_reg(8'hf8, 8'h5a);
      wr_reg(8'he8, 8'ha5);
      rd_reg(8'he8, 8'ha5);
      wr_reg(8'ha8, 8'h7f);
      rd_reg(8'ha8, 8'h7f);
      wr_reg(8'h10, 8'hff);
      rd_reg(8'h10, 8'h00);
      cfg(1'b0, '0, '0);
   endtask : t_regs

   // A pending timer 0 request waits for both its own and the global enable.
   task automatic t_global;
      cfg(1'b0, 15'h0008, '0);
      pulse(15'h0008, '0, 1'b0);
      no_call(80);
      cfg(1'b1, 15'h1000, '0);
      no_call(80);
      cfg(1'b1, 15'h0008, '0);
      wait_call(3, 2'b01);
      pulse('0, '0, 1'b1);
      chk({14'h0, level_act}, 16'h0000);
      no_call(80);
   endtask : t_global

   // All fifteen at once: served one by one in polling order.
   task automatic t_order;
      pin1_edge <= 1'b1;
      cfg(1'b1, 15'h7fff, '0);
      pulse(15'h7fff, '0, 1'b0);
      for (int i = 0; i < 15; i++) begin
         wait_call(i, 2'b01);
         pulse('0, 15'h0001 << i, 1'b1);
      end
      no_call(80);
   endtask : t_order

   // A blocked request that drops as the return executes is never served.
   // Pin 0 is level triggered here, so the unit must leave its flag alone.
   task automatic t_drop;
      pin0_edge <= 1'b0;
      cfg(1'b1, 15'h0011, '0);
      pulse(15'h0001, '0, 1'b0);
      wait_call(0, 2'b01);
      pulse(15'h0010, '0, 1'b0);
      no_call(60);
      pulse('0, 15'h0011, 1'b1);
      no_call(80);
      pin0_edge <= 1'b1;
   endtask : t_drop

   // Nesting of levels with slow instruction ends.
   task automatic t_nest;
      @(posedge clk);
      slow <= 1'b1;
      cfg(1'b1, 15'h3201, 15'h3000);
      pulse(15'h0201, '0, 1'b0);
      wait_call(0, 2'b01);
      pulse(15'h2000, '0, 1'b0);
      wait_call(13, 2'b11);
      rd_reg(8'hf9, 8'hcd);
      pulse(15'h1000, 15'h2000, 1'b0);
      no_call(60);
      pulse('0, '0, 1'b1);
      chk({14'h0, level_act}, 16'h0001);
      wait_call(12, 2'b11);
      pulse('0, 15'h1000, 1'b1);
      pulse('0, '0, 1'b1);
      chk({14'h0, level_act}, 16'h0000);
      wait_call(9, 2'b01);
      pulse(15'h2001, '0, 1'b1);
      wait_call(13, 2'b10);
      pulse('0, 15'h2000, 1'b1);
      wait_call(0, 2'b01);
      pulse('0, '0, 1'b1);
      slow <= 1'b0;
   endtask : t_nest

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // Reset for sixteen cycles, then leave room for the internal release.
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_global();
      t_order();
      t_drop();
      t_nest();
      give_verdict();
   end
endmodule : irq_unit_tb_top
`default_nettype wire
